// File: verilog/ifgm_flags_pinmux.v
// status flags and multi-function pin multiplexer of the codec
// Notes on behaviour
// - live bits 7..5 show current short at left, right, common headphone drivers
// - button flag bit 3 stays set until register 14 is read
// - live bit 2 is 1 while a headset is present
// - live bits 1,0 are 1 while left/right record power is below noise gate
// - flag bits are read-only, reset to 0; bit 4 reserved, never written
// - function 0000 disables pin, 0001 record word clock, 1010 bus word clock
// - functions 0010..0101 drive selected clock divided by 1, 2, 4, 8
// - functions 0110 and 0111 drive the short-circuit interrupt
// - 1000 makes pin an input, 1001 an output from the value bit
// - 1100 drives active-high button-press interrupt
// - 1101 headset; 1110 headset or button; 1111 any event source
// - control bit 3 picks pll clock (0) or divider mux clock (1)
// - bit 2 low: single 2 ms pulse; high: repeat until register 96 read
// - control bit 1 reads the pin level in input mode
// - control bit 0 sets pin level in output mode
// - sticky bit 2 latches on any headset insertion or removal
`timescale 1ns/1ps
`default_nettype none
`include "ifgm_map.vh"

module ifgm_flags_pinmux #(
    parameter [31:0] PULSE_CYC = `IFGM_PULSE_US * `IFGM_CLK_MHZ,
    parameter [31:0] GAP_CYC   = `IFGM_GAP_US * `IFGM_CLK_MHZ
) (
    input  wire        core_clk_i,
    input  wire        rst_n_i,
    // register port
    input  wire [6:0]  reg_addr_i,
    input  wire        reg_wr_i,
    input  wire        reg_rd_i,
    input  wire [7:0]  reg_wdata_i,
    output reg  [7:0]  reg_rdata_o,
    // detector conditions
    input  wire        short_left_i,
    input  wire        short_right_i,
    input  wire        short_common_i,
    input  wire        button_press_i,
    input  wire        headset_present_i,
    input  wire        gate_left_i,
    input  wire        gate_right_i,
    // clock sources and word clocks
    input  wire        pll_clk_i,
    input  wire        clkdiv_mux_i,
    input  wire        adc_wclk_i,
    input  wire        bus_wclk_i,
    input  wire        bus_wclk_dir_out_i,
    output wire        bus_wclk_in_o,
    // multi_function_pin
    input  wire        pin_in_i,
    output reg         pin_out_o,
    output reg         pin_oe_o
);

    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    reg [10:0] sync_a;
    reg [10:0] sync_b;

    always @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            sync_a <= 11'h000;
            sync_b <= 11'h000;
        end else begin
            sync_a <= {bus_wclk_i, adc_wclk_i, clkdiv_mux_i, pll_clk_i, pin_in_i,
                       gate_right_i, gate_left_i, headset_present_i, button_press_i,
                       short_common_i, short_right_i} ;
            sync_b <= sync_a;
        end
    end

    reg sync_short_left_a;
    reg sync_short_left_b;

    always @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            sync_short_left_a <= 1'b0;
            sync_short_left_b <= 1'b0;
        end else begin
            sync_short_left_a <= short_left_i;
            sync_short_left_b <= sync_short_left_a;
        end
    end

    wire s_short_left   = sync_short_left_b;
    wire s_short_right  = sync_b[0];
    wire s_short_common = sync_b[1];
    wire s_button       = sync_b[2];
    wire s_headset      = sync_b[3];
    wire s_gate_left    = sync_b[4];
    wire s_gate_right   = sync_b[5];
    wire s_pin          = sync_b[6];
    wire s_pll_clk      = sync_b[7];
    wire s_div_clk      = sync_b[8];
    wire s_adc_wclk     = sync_b[9];
    wire s_bus_wclk     = sync_b[10];

    // ------------------------------------------------------------
    // live flags
    // ------------------------------------------------------------
    reg [7:0] live;

    always @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            live <= `IFGM_RESET_BYTE;
        end else begin
            live[7] <= s_short_left;
            live[6] <= s_short_right;
            live[5] <= s_short_common;
            live[4] <= 1'b0;
            live[3] <= s_button;
            live[2] <= s_headset;
            live[1] <= s_gate_left;
            live[0] <= s_gate_right;
        end
    end

    // ------------------------------------------------------------
    // event edges
    // ------------------------------------------------------------
    reg [7:0] live_prev;

    always @(posedge core_clk_i) begin
        if (!rst_n_i)
            live_prev <= `IFGM_RESET_BYTE;
        else
            live_prev <= live;
    end

    wire [7:0] rise = live & ~live_prev;
    wire       headset_change = live[2] ^ live_prev[2];
    wire       short_evt = |rise[7:5];
    wire       button_evt = rise[3];
    wire       gate_evt = |rise[1:0];

    wire rd_sticky = reg_rd_i && (reg_addr_i == `IFGM_ADDR_STICKY);
    wire rd_button = reg_rd_i && (reg_addr_i == `IFGM_ADDR_BUTTON_CLR);

    // ------------------------------------------------------------
    // sticky flags and button flag
    // ------------------------------------------------------------
    reg [7:0] sticky;
    reg       button_sticky;
    wire [7:0] sticky_set = {rise[7:5], 1'b0, rise[3], headset_change, rise[1:0]};

    always @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            sticky        <= `IFGM_RESET_BYTE;
            button_sticky <= 1'b0;
        end else begin
            // set wins over the read clear
            if (rd_sticky)
                sticky <= sticky_set;
            else
                sticky <= sticky | sticky_set;
            if (button_evt)
                button_sticky <= 1'b1;
            else if (rd_button)
                button_sticky <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // pin control register
    // ------------------------------------------------------------
    reg [7:0] pinctl;
    wire [3:0] fn = pinctl[`IFGM_FN_HI:`IFGM_FN_LO];

    always @(posedge core_clk_i) begin
        if (!rst_n_i)
            pinctl <= `IFGM_RESET_BYTE;
        else if (reg_wr_i && (reg_addr_i == `IFGM_ADDR_PINCTL))
            pinctl <= reg_wdata_i & `IFGM_PINCTL_WMASK;
    end

    // ------------------------------------------------------------
    // register read data
    // ------------------------------------------------------------
    reg [7:0] next_rdata;

    always @* begin
        case (reg_addr_i)
            `IFGM_ADDR_STICKY: next_rdata = sticky;
            `IFGM_ADDR_LIVE: begin
                next_rdata = live;
                next_rdata[3] = button_sticky;
            end
            `IFGM_ADDR_PINCTL: begin
                next_rdata = pinctl;
                next_rdata[`IFGM_GPIN_BIT] = s_pin;
            end
            default: next_rdata = `IFGM_RESET_BYTE;
        endcase
    end

    always @(posedge core_clk_i) begin
        if (!rst_n_i)
            reg_rdata_o <= `IFGM_RESET_BYTE;
        else if (reg_rd_i)
            reg_rdata_o <= next_rdata;
    end

    // ------------------------------------------------------------
    // clock divider on the selected source
    // ------------------------------------------------------------
    wire src_clk = pinctl[`IFGM_CLKSEL_BIT] ? s_div_clk : s_pll_clk;
    reg  src_prev;
    reg [2:0] div_cnt;

    always @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            src_prev <= 1'b0;
            div_cnt  <= 3'h0;
        end else begin
            src_prev <= src_clk;
            if (src_clk && !src_prev)
                div_cnt <= div_cnt + 3'h1;
        end
    end

    // ------------------------------------------------------------
    // interrupt pulse generation
    // ------------------------------------------------------------
    reg irq_evt;

    always @* begin
        case (fn)
            `IFGM_FN_SHORT_A: irq_evt = short_evt;
            `IFGM_FN_SHORT_B: irq_evt = short_evt;
            `IFGM_FN_BUTTON:  irq_evt = button_evt;
            `IFGM_FN_HEADSET: irq_evt = headset_change;
            `IFGM_FN_HS_BTN:  irq_evt = headset_change | button_evt;
            `IFGM_FN_ANY: irq_evt = headset_change | button_evt | short_evt | gate_evt;
            default:          irq_evt = 1'b0;
        endcase
    end

    wire irq_pulse;

    ifgm_pulse_timer #(
        .PULSE_CYC (PULSE_CYC),
        .GAP_CYC   (GAP_CYC)
    ) u_pulse (
        .core_clk_i (core_clk_i),
        .rst_n_i    (rst_n_i),
        .trigger_i  (irq_evt),
        .repeat_i   (pinctl[`IFGM_REPEAT_BIT]),
        .stop_i     (rd_sticky),
        .pulse_o    (irq_pulse)
    );

    // ------------------------------------------------------------
    // pin output multiplexer
    // ------------------------------------------------------------
    reg next_out;
    reg next_oe;

    always @* begin
        next_out = 1'b0;
        next_oe  = 1'b1;
        case (fn)
            `IFGM_FN_OFF:      next_oe  = 1'b0;
            `IFGM_FN_ADC_WCLK: next_out = s_adc_wclk;
            `IFGM_FN_DIV1:     next_out = src_clk;
            `IFGM_FN_DIV2:     next_out = div_cnt[0];
            `IFGM_FN_DIV4:     next_out = div_cnt[1];
            `IFGM_FN_DIV8:     next_out = div_cnt[2];
            `IFGM_FN_GPIN:     next_oe  = 1'b0;
            `IFGM_FN_GPOUT:    next_out = pinctl[`IFGM_GPOUT_BIT];
            `IFGM_FN_BUS_WCLK: begin
                next_out = s_bus_wclk;
                next_oe  = bus_wclk_dir_out_i;
            end
            `IFGM_FN_UNUSED:   next_oe  = 1'b0;
            default:           next_out = irq_pulse;
        endcase
    end

    always @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            pin_out_o <= 1'b0;
            pin_oe_o  <= 1'b0;
        end else begin
            pin_out_o <= next_out;
            pin_oe_o  <= next_oe;
        end
    end

    // ------------------------------------------------------------
    // pin level seen as bus word clock when the pin is an input
    // ------------------------------------------------------------
    reg wclk_in_level;

    always @(posedge core_clk_i) begin
        if (!rst_n_i)
            wclk_in_level <= 1'b0;
        else
            wclk_in_level <= (fn == `IFGM_FN_BUS_WCLK) && !bus_wclk_dir_out_i && s_pin;
    end

    assign bus_wclk_in_o = wclk_in_level;

endmodule
`default_nettype wire

// File: verilog/ifgm_map.vh
// register map, field positions and timing constants for the flag and pin-mux block
`ifndef IFGM_MAP_VH
`define IFGM_MAP_VH

`define IFGM_ADDR_STICKY      7'h60
`define IFGM_ADDR_LIVE        7'h61
`define IFGM_ADDR_PINCTL      7'h62
`define IFGM_ADDR_BUTTON_CLR  7'h0e

`define IFGM_FN_HI            7
`define IFGM_FN_LO            4
`define IFGM_CLKSEL_BIT       3
`define IFGM_REPEAT_BIT       2
`define IFGM_GPIN_BIT         1
`define IFGM_GPOUT_BIT        0
`define IFGM_RESERVED_BIT     4
`define IFGM_PINCTL_WMASK     8'hfd
`define IFGM_RESET_BYTE       8'h00

`define IFGM_FN_OFF           4'h0
`define IFGM_FN_ADC_WCLK      4'h1
`define IFGM_FN_DIV1          4'h2
`define IFGM_FN_DIV2          4'h3
`define IFGM_FN_DIV4          4'h4
`define IFGM_FN_DIV8          4'h5
`define IFGM_FN_SHORT_A       4'h6
`define IFGM_FN_SHORT_B       4'h7
`define IFGM_FN_GPIN          4'h8
`define IFGM_FN_GPOUT         4'h9
`define IFGM_FN_BUS_WCLK      4'ha
`define IFGM_FN_UNUSED        4'hb
`define IFGM_FN_BUTTON        4'hc
`define IFGM_FN_HEADSET       4'hd
`define IFGM_FN_HS_BTN        4'he
`define IFGM_FN_ANY           4'hf

`define IFGM_CLK_MHZ          100
`define IFGM_PULSE_US         2000
`define IFGM_GAP_US           2000

`endif

// File: verilog/ifgm_pulse_timer.v
// interrupt pulse shaper: one 2 ms pulse or repeating pulses on the pin
`timescale 1ns/1ps
`default_nettype none
`include "ifgm_map.vh"

module ifgm_pulse_timer #(
    parameter [31:0] PULSE_CYC = `IFGM_PULSE_US * `IFGM_CLK_MHZ,
    parameter [31:0] GAP_CYC   = `IFGM_GAP_US * `IFGM_CLK_MHZ
) (
    input  wire        core_clk_i,
    input  wire        rst_n_i,
    input  wire        trigger_i,
    input  wire        repeat_i,
    input  wire        stop_i,
    output reg         pulse_o
);

    localparam [1:0] ST_IDLE = 2'b00;
    localparam [1:0] ST_HIGH = 2'b01;
    localparam [1:0] ST_GAP  = 2'b10;

    reg [1:0]  state;
    reg [31:0] count;
    reg        pending;

    // an event in the same cycle as the flag read keeps the repeat going
    wire       keep_repeating = repeat_i && (trigger_i || (pending && !stop_i));

    always @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            state   <= ST_IDLE;
            count   <= 32'h0000_0000;
            pulse_o <= 1'b0;
            pending <= 1'b0;
        end else begin
            pending <= keep_repeating;
            case (state)
                ST_IDLE: begin
                    if (trigger_i) begin
                        state   <= ST_HIGH;
                        count   <= PULSE_CYC - 32'h0000_0001;
                        pulse_o <= 1'b1;
                    end
                end
                ST_HIGH: begin
                    if (count == 32'h0000_0000) begin
                        pulse_o <= 1'b0;
                        if (keep_repeating) begin
                            state <= ST_GAP;
                            count <= GAP_CYC - 32'h0000_0001;
                        end else begin
                            state <= ST_IDLE;
                        end
                    end else begin
                        count <= count - 32'h0000_0001;
                    end
                end
                ST_GAP: begin
                    if (!keep_repeating) begin
                        state <= ST_IDLE;
                    end else if (count == 32'h0000_0000) begin
                        state   <= ST_HIGH;
                        count   <= PULSE_CYC - 32'h0000_0001;
                        pulse_o <= 1'b1;
                    end else begin
                        count <= count - 32'h0000_0001;
                    end
                end
                default: begin
                    state   <= ST_IDLE;
                    pulse_o <= 1'b0;
                end
            endcase
        end
    end

endmodule
`default_nettype wire

// File: tb/ifgm_flags_pinmux_properties.sv
// assertion checker for the flag and pin-mux block
`timescale 1ns/1ps
`default_nettype none
module ifgm_flags_pinmux_properties #(
    parameter int PULSE_CYC = 20,
    parameter int GAP_CYC   = 20
) (
    input wire logic       core_clk_i,
    input wire logic       rst_n_i,
    input wire logic [6:0] reg_addr_i,
    input wire logic       reg_wr_i,
    input wire logic       reg_rd_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic [7:0] reg_rdata_o,
    input wire logic       pin_out_o,
    input wire logic       pin_oe_o
);
    // ------------------------------------------------------------
    // shadow of the pin control byte and pulse length counter
    // ------------------------------------------------------------
    logic [7:0]  ctl;
    logic [31:0] hi_cnt;
    logic        armed;
    wire         wr_ctl = reg_wr_i && reg_addr_i == 7'h62;
    wire  [3:0]  fn     = ctl[7:4];
    wire         irq_fn = fn == 4'h6 || fn == 4'h7 || fn >= 4'hc;
    // armed once the pin was seen low after the last control register write
    always @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            ctl    <= 8'h00;
            hi_cnt <= 0;
            armed  <= 1'b0;
        end else begin
            ctl    <= wr_ctl ? (reg_wdata_i & 8'hfd) : ctl;
            hi_cnt <= pin_out_o ? hi_cnt + 1 : 0;
            armed  <= wr_ctl ? 1'b0 : (!pin_out_o || armed);
        end
    end
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);
    live_bit4_zero_a: assert property (reg_rd_i && reg_addr_i == 7'h61 |=> !reg_rdata_o[4])
        else $error("live flag reserved bit reads one");
    sticky_bit4_zero_a: assert property (reg_rd_i && reg_addr_i == 7'h60 |=> !reg_rdata_o[4])
        else $error("sticky flag reserved bit reads one");
    rdata_hold_a: assert property (!reg_rd_i |=> $stable(reg_rdata_o))
        else $error("read data moved without a read");
    ctl_readback_a: assert property (reg_rd_i && reg_addr_i == 7'h62 |=>
        reg_rdata_o[7:2] == $past(ctl[7:2]) && reg_rdata_o[0] == $past(ctl[0]))
        else $error("pin control readback wrong");
    pin_idle_a: assert property ((fn == 4'h0 || fn == 4'h8 || fn == 4'hb) && $stable(ctl)
        |-> !pin_oe_o) else $error("pin driven in an undriven function");
    gp_out_a: assert property (fn == 4'h9 && $stable(ctl) |-> pin_oe_o && pin_out_o == ctl[0])
        else $error("general output level wrong");
    drive_on_a: assert property (fn inside {4'h1, [4'h2:4'h7], [4'hc:4'hf]} && $stable(ctl)
        |-> pin_oe_o) else $error("pin not driven in an output function");
    pulse_width_a: assert property ($fell(pin_out_o) && irq_fn && armed |-> hi_cnt == PULSE_CYC)
        else $error("interrupt pulse length wrong");
    pulse_bound_a: assert property (irq_fn && armed |-> hi_cnt <= PULSE_CYC)
        else $error("interrupt pulse too long");
    cover property (reg_rd_i && reg_addr_i == 7'h62);
    cover property ($fell(pin_out_o) && irq_fn && armed);
    cover property (fn == 4'h9 && pin_out_o);
endmodule
`default_nettype wire

// File: tb/ifgm_host_model.sv
// host side of the multi_function_pin: drives it when released, counts rising edges
`timescale 1ns/1ps
`default_nettype none
module ifgm_host_model (
    input  wire logic        core_clk_i,
    input  wire logic        pin_out_i,
    input  wire logic        pin_oe_i,
    input  wire logic        drive_lvl_i,
    output wire logic        pin_in_o,
    output var  logic [15:0] rise_cnt_o
);
    logic last = 1'b0;
    // released pin takes the host level, so input mode sees a real value
    assign pin_in_o = pin_oe_i ? pin_out_i : drive_lvl_i;
    initial rise_cnt_o = 16'h0000;
    always @(posedge core_clk_i) begin
        if (pin_in_o && !last) begin
            rise_cnt_o <= rise_cnt_o + 16'h0001;
        end
        last <= pin_in_o;
    end
endmodule
`default_nettype wire

// File: tb/tb_ifgm_flags_pinmux.sv
// self-checking bench for the flag and pin-mux block
`timescale 1ns/1ps
`default_nettype none
module tb_ifgm_flags_pinmux;
    logic        core_clk_i, rst_n_i, reg_wr_i, reg_rd_i, host_lvl;
    logic [6:0]  reg_addr_i;
    logic [7:0]  reg_wdata_i, d;
    logic        short_left_i, short_right_i, short_common_i, button_press_i;
    logic        headset_present_i, gate_left_i, gate_right_i;
    logic        pll_clk_i, clkdiv_mux_i, adc_wclk_i, bus_wclk_i, bus_dir;
    wire  [7:0]  reg_rdata_o;
    wire         pin_out_o, pin_oe_o, pin_in_i, bus_wclk_in_o;
    wire  [15:0] rise_cnt;
    logic [15:0] c0, n;
    int          fail_count, n_checks;
    logic [15:0] rows [4] = '{16'ha4a4, 16'h4242, 16'h2121, 16'h0303};
    ifgm_flags_pinmux #(.PULSE_CYC(32'd20), .GAP_CYC(32'd20)) u_dut (
        .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i),
        .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i),
        .reg_rdata_o(reg_rdata_o), .short_left_i(short_left_i),
        .short_right_i(short_right_i), .short_common_i(short_common_i),
        .button_press_i(button_press_i), .headset_present_i(headset_present_i),
        .gate_left_i(gate_left_i), .gate_right_i(gate_right_i), .pll_clk_i(pll_clk_i),
        .clkdiv_mux_i(clkdiv_mux_i), .adc_wclk_i(adc_wclk_i), .bus_wclk_i(bus_wclk_i),
        .bus_wclk_dir_out_i(bus_dir), .bus_wclk_in_o(bus_wclk_in_o), .pin_in_i(pin_in_i),
        .pin_out_o(pin_out_o), .pin_oe_o(pin_oe_o));
    ifgm_host_model u_host (.core_clk_i(core_clk_i), .pin_out_i(pin_out_o),
        .pin_oe_i(pin_oe_o), .drive_lvl_i(host_lvl), .pin_in_o(pin_in_i),
        .rise_cnt_o(rise_cnt));
    // ------------------------------------------------------------
    // clocks, bus tasks and comparison
    // ------------------------------------------------------------
    initial begin
        core_clk_i = 1'b0;
        forever #5 core_clk_i = ~core_clk_i;
    end
    // source clocks of 8 and 12 core cycles, changed 1 ns after an edge
    initial begin
        clkdiv_mux_i = 1'b0;
        #6;
        forever #40 clkdiv_mux_i = ~clkdiv_mux_i;
    end
    initial begin
        pll_clk_i = 1'b0;
        #6;
        forever #60 pll_clk_i = ~pll_clk_i;
    end
    task automatic tick;
        @(posedge core_clk_i);
        #1;
    endtask
    task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] v);
        reg_addr_i = 7'h62;
        reg_wdata_i = v;
        reg_wr_i = 1'b1;
        tick;
        reg_wr_i = 1'b0;
    endtask
    task automatic rd(input logic [6:0] a);
        reg_addr_i = a;
        reg_rd_i = 1'b1;
        tick;
        reg_rd_i = 1'b0;
        tick;
        d = reg_rdata_o;
    endtask
    task automatic rdchk(input logic [6:0] a, input logic [7:0] exp);
        rd(a);
        chk("rdata", d, exp);
    endtask
    task automatic det(input logic [7:0] v);
        {short_left_i, short_right_i, short_common_i} = v[7:5];
        button_press_i = v[3];
        headset_present_i = v[2];
        {gate_left_i, gate_right_i} = v[1:0];
        repeat (6) tick;
    endtask
    // one event under a given pin setting; counts pin rises afterwards
    task automatic irq(input logic [7:0] c, input logic [7:0] v);
        wr(c);
        repeat (5) tick;
        c0 = rise_cnt;
        det(v);
        det(v & 8'h04);
        repeat (150) tick;
        n = rise_cnt - c0;
    endtask
    task automatic print_verdict;
        if (fail_count == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    initial begin
        #400000;
        fail_count++;
        print_verdict;
    end
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        {rst_n_i, reg_wr_i, reg_rd_i, host_lvl, reg_addr_i, reg_wdata_i} = '0;
        {short_left_i, short_right_i, short_common_i, button_press_i} = '0;
        {headset_present_i, gate_left_i, gate_right_i} = '0;
        {adc_wclk_i, bus_wclk_i} = '0;
        bus_dir = 1'b1;
        repeat (2) @(posedge core_clk_i);
        #1;
        rst_n_i = 1'b1;
        chk("pin_oe", pin_oe_o, 0);
        rdchk(7'h61, 8'h00);
        rdchk(7'h62, 8'h00);
        foreach (rows[i]) begin
            det(rows[i][15:8]);
            rdchk(7'h61, rows[i][7:0]);
        end
        det(8'h00);
        rd(7'h60);
        rdchk(7'h60, 8'h00);
        det(8'h80);
        rdchk(7'h60, 8'h80);
        rdchk(7'h60, 8'h00);
        det(8'h04);
        rdchk(7'h60, 8'h04);
        det(8'h00);
        rdchk(7'h60, 8'h04);
        det(8'h08);
        det(8'h00);
        rdchk(7'h61, 8'h08);
        rdchk(7'h60, 8'h08);
        rdchk(7'h61, 8'h08);
        rd(7'h0e);
        rdchk(7'h61, 8'h00);
        for (int f = 0; f < 16; f++) begin
            wr({f[3:0], 4'h1});
            repeat (3) tick;
            chk("pin_oe", pin_oe_o, !(f == 0 || f == 8 || f == 11));
        end
        wr(8'h91);
        repeat (3) tick;
        chk("pin_out", pin_out_o, 1);
        wr(8'h8f);
        host_lvl = 1'b1;
        repeat (5) tick;
        rdchk(7'h62, 8'h8f);
        host_lvl = 1'b0;
        repeat (5) tick;
        rdchk(7'h62, 8'h8d);
        // word clocks reach the pin after two sync stages and the output register
        wr(8'h10);
        adc_wclk_i = 1'b1;
        repeat (4) tick;
        chk("adc_wclk_hi", pin_out_o, 1);
        adc_wclk_i = 1'b0;
        repeat (4) tick;
        chk("adc_wclk_lo", pin_out_o, 0);
        wr(8'ha0);
        bus_wclk_i = 1'b1;
        repeat (4) tick;
        chk("bus_wclk_out", {pin_oe_o, pin_out_o}, 2'b11);
        bus_wclk_i = 1'b0;
        bus_dir = 1'b0;
        host_lvl = 1'b1;
        repeat (4) tick;
        chk("bus_wclk_in_hi", {pin_oe_o, bus_wclk_in_o}, 2'b01);
        host_lvl = 1'b0;
        repeat (4) tick;
        chk("bus_wclk_in_lo", bus_wclk_in_o, 0);
        bus_dir = 1'b1;
        for (int k = 0; k < 5; k++) begin
            wr(k < 4 ? {4'h2 + k[3:0], 4'h8} : 8'h20);
            repeat (10) tick;
            c0 = rise_cnt;
            repeat (640) tick;
            n = rise_cnt - c0;
            c0 = k < 4 ? 16'd80 >> k : 16'd53;
            chk("clk_rises", n >= c0 - 1 && n <= c0 + 2, 1);
        end
        irq(8'h60, 8'h80);
        chk("short_irq", n, 1);
        irq(8'hc0, 8'h08);
        chk("button_irq", n, 1);
        irq(8'he0, 8'h08);
        chk("hs_btn_irq", n, 1);
        irq(8'hf0, 8'h02);
        chk("any_irq", n, 1);
        irq(8'hd0, 8'h08);
        chk("hs_only_irq", n, 0);
        irq(8'hd0, 8'h04);
        chk("hs_irq", n, 1);
        irq(8'hc4, 8'h08);
        chk("repeat_irq", n >= 2, 1);
        rd(7'h60);
        repeat (40) tick;
        c0 = rise_cnt;
        repeat (100) tick;
        chk("repeat_stop", rise_cnt - c0, 0);
        print_verdict;
    end
endmodule
bind ifgm_flags_pinmux ifgm_flags_pinmux_properties #(.PULSE_CYC(PULSE_CYC),
    .GAP_CYC(GAP_CYC)) u_chk (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
    .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .pin_out_o(pin_out_o),
    .pin_oe_o(pin_oe_o));
`default_nettype wire
